// ---- bench/ascs_host_model.sv ----
// host model: spi mode 1 master that shifts whole frames
`timescale 1ns/1ps
module ascs_host_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdi,
  input wire logic i_sdo,
  output logic [31:0] o_word,
  output logic o_word_valid
);
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
    o_word = '0;
    o_word_valid = 1'b0;
  end

  // bits after the first skip are collected into o_word
  task automatic frame(input logic [63:0] tx, input int n, input int skip);
    logic [31:0] rx;
    rx = '0;
    o_cs_n = 1'b0;
    #200;
    for (int i = n - 1; i >= 0; i--)
    begin
      o_sclk = 1'b1;
      o_sdi = tx[i];
      #16;
      o_sclk = 1'b0;
      if (n - 1 - i >= skip)
        rx = {rx[30:0], i_sdo};
      #16;
    end
    // released line must not keep looking valid
    o_sdi = ~o_sdi;
    #100;
    o_cs_n = 1'b1;
    if (n > skip)
    begin
      o_word = rx;
      o_word_valid = 1'b1;
      #10;
      o_word_valid = 1'b0;
    end
    #300;
  endtask
endmodule

// ---- bench/ascs_sequencer_assertions.sv ----
// port-level checker of the sensor adc command sequencer
`timescale 1ns/1ps
module ascs_sequencer_assertions
  import ascs_pkg::*;
#(
  parameter int STARTUP_CYCLES = 64,
  parameter int RESET_WAIT_CYCLES = 20
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_sdi,
  input wire logic o_serial_out_with_ready,
  input wire logic o_serial_out_with_ready_oe,
  input wire logic o_result_ready_n,
  input wire logic i_start,
  input wire ascs_pkg::ascs_result_t i_result,
  input wire logic o_conv_run,
  input wire logic o_conv_restart,
  input wire logic o_power_down,
  input wire logic [31:0] o_config,
  input wire logic o_cmd_buffer_ready
);
  logic [16:0] up_cnt;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);

  // saturating count of cycles since reset release
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
      up_cnt <= '0;
    else if (up_cnt != '1)
      up_cnt <= up_cnt + 17'h00001;
  end

  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  a_oe_follows_cs: assert property (o_serial_out_with_ready_oe == !i_cs_n)
    else $error("serial out enable differs from chip select");
  a_flag_on_result: assert property (i_result.valid && o_conv_run |=> !o_result_ready_n)
    else $error("accepted result not flagged");
  a_pdown_no_run: assert property (o_power_down |-> !o_conv_run)
    else $error("conversion runs in power-down");
  a_start_low_stops: assert property (!i_start [*3] |-> !o_conv_run)
    else $error("conversion runs with start pin low");
  a_run_needs_start: assert property (o_conv_run |-> $past(i_start, 2))
    else $error("conversion runs without synced start");
  a_wake_by_reset: assert property ($fell(o_power_down) |-> o_conv_restart)
    else $error("power-down left without reset command");
  a_idle_pin_ready: assert property (i_cs_n |-> o_serial_out_with_ready == o_result_ready_n)
    else $error("idle serial out does not show ready");
  a_startup_no_run: assert property (up_cnt < STARTUP_CYCLES - 2 |-> !o_conv_run)
    else $error("conversion runs during startup hold");
endmodule

bind ascs_sequencer ascs_sequencer_assertions #(
  .STARTUP_CYCLES(STARTUP_CYCLES),
  .RESET_WAIT_CYCLES(RESET_WAIT_CYCLES)
) chk_u (
  .i_clock(i_clock), .i_reset(i_reset), .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_sdi(i_sdi),
  .o_serial_out_with_ready(o_serial_out_with_ready),
  .o_serial_out_with_ready_oe(o_serial_out_with_ready_oe),
  .o_result_ready_n(o_result_ready_n), .i_start(i_start), .i_result(i_result),
  .o_conv_run(o_conv_run), .o_conv_restart(o_conv_restart), .o_power_down(o_power_down),
  .o_config(o_config), .o_cmd_buffer_ready(o_cmd_buffer_ready)
);

// ---- bench/tb_adc_spi_command_sequencer.sv ----
// self-checking bench of the sensor adc command sequencer
`timescale 1ns/1ps
module tb_adc_spi_command_sequencer;
  import ascs_pkg::*;
  logic i_clock, i_reset, i_start, sclk, cs_n, sdi, sdo, sdo_oe, ready_n;
  logic run, restart, pdown, buf_rdy, word_valid, saw_full;
  logic [31:0] cfg, word, r, d, e;
  ascs_result_t res;
  int failures, n_tests, n_restart;
  integer seed;
  logic [31:0] q[$];
  // undriven line shows the inverse so a stale bit cannot pass
  wire logic sdo_line = sdo_oe ? sdo : ~sdo;

  ascs_sequencer #(.STARTUP_CYCLES(64), .RESET_WAIT_CYCLES(20)) dut_u (
    .i_clock(i_clock), .i_reset(i_reset), .i_sclk(sclk), .i_cs_n(cs_n), .i_sdi(sdi),
    .o_serial_out_with_ready(sdo), .o_serial_out_with_ready_oe(sdo_oe),
    .o_result_ready_n(ready_n), .i_start(i_start), .i_result(res), .o_conv_run(run),
    .o_conv_restart(restart), .o_power_down(pdown), .o_config(cfg),
    .o_cmd_buffer_ready(buf_rdy)
  );

  ascs_host_model host_u (
    .o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo_line),
    .o_word(word), .o_word_valid(word_valid)
  );

  initial
  begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge i_clock);
  endtask

  task automatic pulse(input logic [23:0] v);
    @(negedge i_clock);
    res = {1'b1, v};
    @(negedge i_clock);
    res.valid = 1'b0;
  endtask

  initial
  begin
    #2000000;
    failures++;
    end_of_test;
  end

  always @(posedge word_valid)
    check(word, q.pop_front());

  // sampled mid-cycle, away from the edge that launches these flops
  always @(negedge i_clock)
  begin
    if (restart === 1'b1)
      n_restart++;
    if (buf_rdy === 1'b0)
      saw_full = 1'b1;
  end

  initial
  begin
    seed = 32'hB855;
    i_reset = 1'b1;
    i_start = 1'b1;
    res = '0;
    saw_full = 1'b0;
    cyc(8);
    i_reset = 1'b0;
    cyc(10);
    check(run, 1'b0);
    cyc(80);
    check(run, 1'b1);
    i_start = 1'b0;
    cyc(4);
    check(run, 1'b0);
    i_start = 1'b1;
    cyc(4);
    r = $random(seed);
    pulse(r[23:0]);
    cyc(1);
    check(ready_n, 1'b0);
    q.push_back({8'h00, r[23:0]});
    host_u.frame(64'hFFFFFF, 24, 0);
    cyc(10);
    check(ready_n, 1'b1);
    d = $random(seed);
    host_u.frame({16'h4003, d}, 48, 48);
    cyc(10);
    e = {<<8{d}};
    check(cfg, e);
    // reset stalls the interpreter, so the last of the three trailing bytes overflows
    n_restart = 0;
    host_u.frame(64'h06040404, 32, 32);
    cyc(60);
    check(n_restart, 3);
    check(saw_full, 1'b1);
    check(cfg, 32'h0);
    host_u.frame(64'h16, 8, 8);
    d = $random(seed);
    host_u.frame({16'h4003, d}, 48, 48);
    q.push_back(d);
    host_u.frame({16'h2003, 32'h0}, 48, 16);
    // single-byte write from an offset start register
    host_u.frame({16'h4200, 8'hA5}, 24, 24);
    cyc(10);
    check(cfg, {d[7:0], 8'hA5, d[23:16], d[31:24]});
    r = $random(seed);
    pulse(r[23:0]);
    host_u.frame(64'h04, 8, 8);
    cyc(10);
    check(ready_n, 1'b0);
    check(n_restart, 4);
    q.push_back({8'h00, r[23:0]});
    r = $random(seed);
    fork
      host_u.frame(64'h12000000, 32, 8);
      begin
        cyc(10);
        pulse(r[23:0]);
      end
    join
    cyc(10);
    check(ready_n, 1'b0);
    q.push_back({8'h00, r[23:0]});
    host_u.frame(64'h12000000, 32, 8);
    cyc(10);
    host_u.frame(64'h0, 4, 4);
    host_u.frame(64'h02, 8, 8);
    cyc(10);
    check(pdown, 1'b1);
    check(run, 1'b0);
    r = $random(seed);
    pulse(r[23:0]);
    cyc(2);
    check(ready_n, 1'b1);
    host_u.frame(64'h06, 8, 8);
    cyc(40);
    check(pdown, 1'b0);
    end_of_test;
  end
endmodule

// ---- include/ascs_pkg.sv ----
// shared constants and carrier types of the sensor adc command sequencer
package ascs_pkg;

  // ---------------------------------------------------------------
  // command bytes
  // ---------------------------------------------------------------
  localparam logic [7:0] ASCS_CMD_POWER_DOWN = 8'h02;
  localparam logic [7:0] ASCS_CMD_RESTART = 8'h04;
  localparam logic [7:0] ASCS_CMD_RESET = 8'h06;
  localparam logic [7:0] ASCS_CMD_READ_RESULT = 8'h12;
  localparam logic [7:0] ASCS_CMD_STOP_CONTINUOUS = 8'h16;
  localparam logic [3:0] ASCS_OP_REGISTER_READ = 4'h2;
  localparam logic [3:0] ASCS_OP_REGISTER_WRITE = 4'h4;

  // ---------------------------------------------------------------
  // sizes, reset values and timing
  // ---------------------------------------------------------------
  localparam int ASCS_RESULT_BITS = 24;
  localparam int ASCS_REG_COUNT = 4;
  localparam logic [31:0] ASCS_REGS_RESET = 32'h00000000;
  localparam logic [7:0] ASCS_RESULT_DUMMY_BYTES = 8'h03;
  localparam logic [5:0] ASCS_RESULT_SHIFT_BITS = 6'h18;
  localparam logic [5:0] ASCS_REGS_SHIFT_BITS = 6'h20;
  localparam int ASCS_CLOCK_HZ = 20000000;
  localparam int ASCS_STARTUP_CYCLES = 65536;
  localparam int ASCS_RESET_WAIT_NS = 600000;
  localparam int ASCS_RESET_WAIT_CYCLES =
    (ASCS_RESET_WAIT_NS * (ASCS_CLOCK_HZ / 1000000) + 999) / 1000;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ASCS_ST_IDLE = 3'h0,
    ASCS_ST_WR_COUNT = 3'h1,
    ASCS_ST_WR_DATA = 3'h2,
    ASCS_ST_RD_COUNT = 3'h3,
    ASCS_ST_RD_DATA = 3'h4,
    ASCS_ST_RESULT = 3'h5
  } ascs_state_t;

  typedef enum logic [1:0] {
    ASCS_TX_NONE = 2'h0,
    ASCS_TX_RESULT = 2'h1,
    ASCS_TX_REGS = 2'h2
  } ascs_tx_kind_t;

  typedef struct packed {
    logic valid;
    logic [23:0] data;
  } ascs_result_t;

  typedef struct packed {
    logic first;
    logic [7:0] data;
  } ascs_rx_entry_t;

  typedef struct packed {
    logic continuous_readback_mode;
    logic fresh;
    logic [23:0] result;
    logic [31:0] regs;
  } ascs_image_t;

  typedef struct packed {
    logic cs_meta, cs_sync, rxt_meta, rxt_sync, rxt_seen;
    logic cons_meta, cons_sync, cons_seen, start_meta, start_sync;
    logic [16:0] startup_cnt;
    logic [13:0] wait_cnt;
    logic [1:0][8:0] mem;
    logic [1:0] wr_ptr, rd_ptr;
    ascs_state_t state;
    logic [2:0] reg_idx;
    logic [7:0] remain;
    logic [3:0][7:0] regs;
    logic cont_off, power_down, restart, result_ready, fresh;
    logic [23:0] result;
    ascs_image_t image;
  } ascs_core_t;

  typedef struct packed {
    logic [2:0] bit_cnt;
    logic [6:0] shreg;
    logic first;
    logic [7:0] skip;
    logic wr_cnt, rd_pend, req_t;
    ascs_tx_kind_t req_kind;
  } ascs_rx_t;

  typedef struct packed {
    logic [31:0] sh;
    logic [5:0] left;
    logic ack, started;
  } ascs_tx_t;

endpackage

// ---- logic/ascs_sequencer.sv ----
// serial command interpreter of a delta-sigma sensor adc, spi mode 1 slave
`timescale 1ns/1ps
// How it works
// - the serial port works in spi mode 1, clock idle low, second edge samples.
// - conversions run only while the conversion-run pin is high.
// - byte 06h resets the device; host waits 0.6 ms afterwards.
// - byte 16h leaves continuous readback, so results are not shifted unrequested.
// - a new result never disturbs a register or result transfer in progress.
// - 40h, count 03h, four bytes store the four configuration registers in order.
// - 20h, count 03h returns the four configuration registers in order.
// - byte 04h starts a new conversion.
// - chip select high resets the serial interface, dropping partial commands.
// - the ready pin goes low when a new result is available.
// - after 12h the result is shifted out during 24 serial clocks.
// - byte 02h stops conversions and enters power-down.
// - outgoing data changes on rising serial edges, incoming sampled on falling.
// - after reset the device is in continuous readback mode.
// - the device stays in reset for 2^16 system clocks after power-up.
module ascs_sequencer #(
  parameter int STARTUP_CYCLES = ascs_pkg::ASCS_STARTUP_CYCLES,
  parameter int RESET_WAIT_CYCLES = ascs_pkg::ASCS_RESET_WAIT_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_sdi,
  output logic o_serial_out_with_ready,
  output logic o_serial_out_with_ready_oe,
  output logic o_result_ready_n,
  input wire logic i_start,
  input wire ascs_pkg::ascs_result_t i_result,
  output logic o_conv_run,
  output logic o_conv_restart,
  output logic o_power_down,
  output logic [31:0] o_config,
  output logic o_cmd_buffer_ready
);
  import ascs_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic buf_full(input logic [1:0] wr, input logic [1:0] rd);
    buf_full = (wr[1] != rd[1]) && (wr[0] == rd[0]);
  endfunction

  function automatic logic [7:0] plus_one(input logic [7:0] value);
    plus_one = 8'(value + 8'h01);
  endfunction

  ascs_core_t c;
  ascs_core_t next_c;
  ascs_rx_t rx;
  ascs_rx_t next_rx;
  ascs_tx_t tx;
  ascs_tx_t next_tx;
  ascs_rx_entry_t rx_hold;
  logic rx_toggle;
  logic cons_toggle;
  logic byte_done;
  logic consume;
  logic [7:0] rx_byte;

  // ---------------------------------------------------------------
  // link side: receive on falling serial edges
  // ---------------------------------------------------------------
  assign rx_byte = {rx.shreg, i_sdi};
  assign byte_done = (rx.bit_cnt == 3'h7);

  always_comb
  begin
    next_rx = rx;
    next_rx.shreg = {rx.shreg[5:0], i_sdi};
    next_rx.bit_cnt = 3'(rx.bit_cnt + 3'h1);
    if (byte_done)
    begin
      next_rx.first = 1'b0;
      // dummy bytes under a read must not be parsed as commands
      if (rx.skip != 8'h00)
      begin
        next_rx.skip = 8'(rx.skip - 8'h01);
      end
      else if (rx.wr_cnt)
      begin
        next_rx.wr_cnt = 1'b0;
        next_rx.skip = plus_one(rx_byte);
      end
      else if (rx.rd_pend)
      begin
        next_rx.rd_pend = 1'b0;
        next_rx.skip = plus_one(rx_byte);
        next_rx.req_kind = ASCS_TX_REGS;
        next_rx.req_t = ~rx.req_t;
      end
      else if (rx_byte == ASCS_CMD_READ_RESULT)
      begin
        next_rx.skip = ASCS_RESULT_DUMMY_BYTES;
        next_rx.req_kind = ASCS_TX_RESULT;
        next_rx.req_t = ~rx.req_t;
      end
      else if (rx_byte[7:4] == ASCS_OP_REGISTER_WRITE)
      begin
        next_rx.wr_cnt = 1'b1;
      end
      else if (rx_byte[7:4] == ASCS_OP_REGISTER_READ)
      begin
        next_rx.rd_pend = 1'b1;
      end
    end
  end

  // chip select high clears all frame state at once
  always_ff @(negedge i_sclk or posedge i_cs_n)
  begin
    if (i_cs_n)
    begin
      rx <= '0;
      rx.first <= 1'b1;
    end
    else
    begin
      rx <= next_rx;
    end
  end

  // byte hand-off survives chip select; the toggle must never reset mid-use
  always_ff @(negedge i_sclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      rx_hold <= '0;
      rx_toggle <= 1'b0;
    end
    else if (byte_done)
    begin
      rx_hold <= {rx.first, rx_byte};
      rx_toggle <= ~rx_toggle;
    end
  end

  // ---------------------------------------------------------------
  // link side: transmit on rising serial edges
  // ---------------------------------------------------------------
  always_comb
  begin
    next_tx = tx;
    consume = 1'b0;
    if (!tx.started)
    begin
      next_tx.started = 1'b1;
      if (c.image.continuous_readback_mode && c.image.fresh)
      begin
        next_tx.sh = {c.image.result, 8'h00};
        next_tx.left = ASCS_RESULT_SHIFT_BITS;
        consume = 1'b1;
      end
    end
    else if (tx.ack != rx.req_t)
    begin
      next_tx.ack = rx.req_t;
      if (rx.req_kind == ASCS_TX_RESULT)
      begin
        next_tx.sh = {c.image.result, 8'h00};
        next_tx.left = ASCS_RESULT_SHIFT_BITS;
        consume = 1'b1;
      end
      else
      begin
        next_tx.sh = c.image.regs;
        next_tx.left = ASCS_REGS_SHIFT_BITS;
      end
    end
    else if (tx.left != 6'h00)
    begin
      next_tx.sh = {tx.sh[30:0], 1'b0};
      next_tx.left = 6'(tx.left - 6'h01);
    end
  end

  always_ff @(posedge i_sclk or posedge i_cs_n)
  begin
    if (i_cs_n)
      tx <= '0;
    else
      tx <= next_tx;
  end

  always_ff @(posedge i_sclk or posedge i_reset)
  begin
    if (i_reset)
      cons_toggle <= 1'b0;
    else if (consume)
      cons_toggle <= ~cons_toggle;
  end

  // between transfers the pin carries the ready level
  assign o_serial_out_with_ready = (tx.left != 6'h00) ? tx.sh[31] : ~c.result_ready;
  assign o_serial_out_with_ready_oe = ~i_cs_n;

  // ---------------------------------------------------------------
  // core: synchronisers, buffer and command interpreter
  // ---------------------------------------------------------------
  logic startup_done;
  logic waiting;
  logic push;
  logic pop;
  logic full;
  logic empty;
  ascs_rx_entry_t entry;
  ascs_state_t state_in;

  assign startup_done = (c.startup_cnt == 17'(STARTUP_CYCLES));
  assign waiting = (c.wait_cnt != 14'h0000);
  assign full = buf_full(c.wr_ptr, c.rd_ptr);
  assign empty = (c.wr_ptr == c.rd_ptr);
  assign push = (c.rxt_sync != c.rxt_seen);
  // the interpreter stalls during startup and the post-reset wait
  assign pop = !empty && startup_done && !waiting;
  assign entry = c.mem[c.rd_ptr[0]];
  assign state_in = entry.first ? ASCS_ST_IDLE : c.state;

  always_comb
  begin
    next_c = c;
    next_c.restart = 1'b0;
    next_c.cs_meta = i_cs_n;
    next_c.cs_sync = c.cs_meta;
    next_c.rxt_meta = rx_toggle;
    next_c.rxt_sync = c.rxt_meta;
    next_c.rxt_seen = c.rxt_sync;
    next_c.cons_meta = cons_toggle;
    next_c.cons_sync = c.cons_meta;
    next_c.cons_seen = c.cons_sync;
    next_c.start_meta = i_start;
    next_c.start_sync = c.start_meta;
    if (!startup_done)
      next_c.startup_cnt = 17'(c.startup_cnt + 17'h00001);
    if (waiting)
      next_c.wait_cnt = 14'(c.wait_cnt - 14'h0001);
    // a full buffer drops the byte; the ready output shows it
    if (push && !full)
    begin
      next_c.mem[c.wr_ptr[0]] = rx_hold;
      next_c.wr_ptr = 2'(c.wr_ptr + 2'h1);
    end
    if (pop)
    begin
      next_c.rd_ptr = 2'(c.rd_ptr + 2'h1);
      next_c.state = state_in;
      case (state_in)
        ASCS_ST_IDLE:
        begin
          if (entry.data == ASCS_CMD_RESET)
          begin
            next_c.regs = ASCS_REGS_RESET;
            next_c.cont_off = 1'b0;
            next_c.power_down = 1'b0;
            next_c.result_ready = 1'b0;
            next_c.fresh = 1'b0;
            next_c.restart = 1'b1;
            next_c.wait_cnt = 14'(RESET_WAIT_CYCLES);
          end
          else if (entry.data == ASCS_CMD_STOP_CONTINUOUS)
            next_c.cont_off = 1'b1;
          else if (entry.data == ASCS_CMD_RESTART)
            next_c.restart = 1'b1;
          else if (entry.data == ASCS_CMD_POWER_DOWN)
            next_c.power_down = 1'b1;
          else if (entry.data == ASCS_CMD_READ_RESULT)
          begin
            next_c.remain = 8'(ASCS_RESULT_DUMMY_BYTES - 8'h01);
            next_c.state = ASCS_ST_RESULT;
          end
          else if (entry.data[7:4] == ASCS_OP_REGISTER_WRITE)
          begin
            next_c.reg_idx = {1'b0, entry.data[1:0]};
            next_c.state = ASCS_ST_WR_COUNT;
          end
          else if (entry.data[7:4] == ASCS_OP_REGISTER_READ)
            next_c.state = ASCS_ST_RD_COUNT;
        end
        ASCS_ST_WR_COUNT:
        begin
          next_c.remain = entry.data;
          next_c.state = ASCS_ST_WR_DATA;
        end
        ASCS_ST_WR_DATA:
        begin
          if (!c.reg_idx[2])
            next_c.regs[c.reg_idx[1:0]] = entry.data;
          if (c.reg_idx != 3'h4)
            next_c.reg_idx = 3'(c.reg_idx + 3'h1);
          if (c.remain == 8'h00)
            next_c.state = ASCS_ST_IDLE;
          else
            next_c.remain = 8'(c.remain - 8'h01);
        end
        ASCS_ST_RD_COUNT:
        begin
          next_c.remain = entry.data;
          next_c.state = ASCS_ST_RD_DATA;
        end
        ASCS_ST_RD_DATA, ASCS_ST_RESULT:
        begin
          if (c.remain == 8'h00)
            next_c.state = ASCS_ST_IDLE;
          else
            next_c.remain = 8'(c.remain - 8'h01);
        end
        default:
          next_c.state = ASCS_ST_IDLE;
      endcase
    end
    // consumption clears ready; a result landing now wins over it
    if (c.cons_sync != c.cons_seen)
    begin
      next_c.result_ready = 1'b0;
      next_c.fresh = 1'b0;
    end
    if (i_result.valid && o_conv_run)
    begin
      next_c.result = i_result.data;
      next_c.result_ready = 1'b1;
      next_c.fresh = 1'b1;
    end
    // image only moves while the frame is closed, so the link sees it static
    if (c.cs_sync)
    begin
      next_c.image.continuous_readback_mode = ~c.cont_off;
      next_c.image.fresh = c.fresh;
      next_c.image.result = c.result;
      next_c.image.regs = {c.regs[0], c.regs[1], c.regs[2], c.regs[3]};
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      c <= '0;
      c.regs <= ASCS_REGS_RESET;
    end
    else
    begin
      c <= next_c;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_conv_run = startup_done && c.start_sync && !c.power_down && !waiting;
  assign o_conv_restart = c.restart;
  assign o_power_down = c.power_down;
  assign o_result_ready_n = ~c.result_ready;
  assign o_config = {c.regs[3], c.regs[2], c.regs[1], c.regs[0]};
  assign o_cmd_buffer_ready = !full;

endmodule
